// >>> rtl/chan01_mode_ctl.v
// channel 0/1 mode control: register, input filter, edge prescaler,
// channel 0 compare shadow and prepared output.
// assumes counter, update event and dead-time clock enable come from the
// surrounding timer on mclk_i; pins and the internal trigger are asynchronous.
`include "chan01_mode_map.vh"
`default_nettype none
module chan01_mode_ctl
(
   input wire mclk_i,
   input wire arst_n_i,
   input wire [`CMC_ADDR_W-1:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire [1:0] ch_pin_i,
   input wire internal_trigger_i,
   input wire external_trigger_filtered_i,
   input wire dead_time_tick_i,
   input wire update_event_i,
   input wire [`CMC_CMP_W-1:0] counter_i,
   output reg [1:0] capture_o,
   output reg ch0_prepared_output_o,
   output reg [`CMC_CMP_W-1:0] ch0_compare_value_o
);
   // ****************************************************************
   // registers
   // ****************************************************************
   reg [15:0] mode_ctl;
   reg [4:0] ctrl;
   reg [`CMC_CMP_W-1:0] cmp_shadow;
   reg [15:0] next_mode_ctl;
   wire [1:0] ch_en;
   wire [1:0] protection_level;
   wire sel_mode;
   wire sel_cmp;
   wire [1:0] ch0_ms;
   wire [2:0] ch0_octl;
   assign ch_en = ctrl[`CMC_CTRL_CH1_EN:`CMC_CTRL_CH0_EN];
   assign protection_level = ctrl[`CMC_CTRL_PROTECTION_LEVEL_LSB+1:`CMC_CTRL_PROTECTION_LEVEL_LSB];
   assign sel_mode = wr_i && (addr_i == `CMC_OFS_MODE_CTL);
   assign sel_cmp = wr_i && (addr_i == `CMC_OFS_CMP_VALUE);
   assign ch0_ms = mode_ctl[`CMC_CH0_MS_LSB+1:`CMC_CH0_MS_LSB];
   assign ch0_octl = mode_ctl[`CMC_CH0_OCTL_LSB+2:`CMC_CH0_OCTL_LSB];

   always @*
   begin
      next_mode_ctl = wdata_i[15:0];
      // hold mode fields of enabled channels
      if (ch_en[0])
      begin
         next_mode_ctl[1:0] = mode_ctl[1:0];
      end
      if (ch_en[1])
      begin
         next_mode_ctl[9:8] = mode_ctl[9:8];
      end
      if (protection_level == `CMC_PROTECTION_LEVEL_LOCKED && ch0_ms == `CMC_MS_OUTPUT)
      begin
         next_mode_ctl[`CMC_CH0_SHADOW_BIT] =
            mode_ctl[`CMC_CH0_SHADOW_BIT];
         next_mode_ctl[6:4] = mode_ctl[6:4];
      end
   end

   always @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         mode_ctl <= `CMC_MODE_CTL_RESET;
         ctrl <= 5'h00;
         cmp_shadow <= 16'h0000;
         ch0_compare_value_o <= 16'h0000;
      end
      else
      begin
         if (sel_mode)
         begin
            mode_ctl <= next_mode_ctl;
         end
         if (wr_i && addr_i == `CMC_OFS_CTRL)
         begin
            ctrl <= wdata_i[4:0];
         end
         if (sel_cmp)
         begin
            cmp_shadow <= wdata_i[`CMC_CMP_W-1:0];
         end
         if (sel_cmp && !mode_ctl[`CMC_CH0_SHADOW_BIT])
         begin
            ch0_compare_value_o <= wdata_i[`CMC_CMP_W-1:0];
         end
         else if (mode_ctl[`CMC_CH0_SHADOW_BIT] && update_event_i)
         begin
            ch0_compare_value_o <= cmp_shadow;
         end
      end
   end

   // ****************************************************************
   // input synchronisers, one per channel plus one for the internal trigger, and filters, one per channel
   // ****************************************************************
   reg [1:0] pin_meta;
   reg [1:0] pin_sync;
   reg trig_meta;
   reg trig_sync;
   reg trig_prev;
   wire [1:0] filtered;
   wire [1:0] rise;
   always @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end
      else
      begin
         pin_meta <= ch_pin_i;
         pin_sync <= pin_meta;
         trig_meta <= internal_trigger_i;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end
   wire trig_rise;
   assign trig_rise = trig_sync && !trig_prev;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_ch
         reg [4:0] div_cnt;
         reg [2:0] same_cnt;
         reg flt_level;
         reg flt_prev;
         reg [2:0] edge_cnt;
         reg [3:0] code;
         reg [2:0] need;
         reg [4:0] div;
         reg samp;
         reg [1:0] ms;
         reg [1:0] psc;
         reg [2:0] psc_mask;
         reg src;
         wire src_edge;
         always @*
         begin
            code = mode_ctl[8*gi+7 -: 4];
            ms = mode_ctl[8*gi+1 -: 2];
            psc = mode_ctl[8*gi+3 -: 2];
            need = 3'd0;
            div = 5'd0;
            case (code)
               4'h1: need = 3'd1;
               4'h2: need = 3'd3;
               4'h3: need = 3'd7;
               4'h4: begin need = 3'd5; div = 5'd1; end
               4'h5: begin need = 3'd7; div = 5'd1; end
               4'h6: begin need = 3'd5; div = 5'd3; end
               4'h7: begin need = 3'd7; div = 5'd3; end
               4'h8: begin need = 3'd5; div = 5'd7; end
               4'h9: begin need = 3'd7; div = 5'd7; end
               4'ha: begin need = 3'd4; div = 5'd15; end
               4'hb: begin need = 3'd5; div = 5'd15; end
               4'hc: begin need = 3'd7; div = 5'd15; end
               4'hd: begin need = 3'd4; div = 5'd31; end
               4'he: begin need = 3'd5; div = 5'd31; end
               4'hf: begin need = 3'd7; div = 5'd31; end
               default: need = 3'd0;
            endcase
            samp = (code < 4'h4) ? 1'b1 :
               (dead_time_tick_i && div_cnt == div);
            case (psc)
               2'b00: psc_mask = 3'd0;
               2'b01: psc_mask = 3'd1;
               2'b10: psc_mask = 3'd3;
               default: psc_mask = 3'd7;
            endcase
            case (ms)
               `CMC_MS_OWN: src = flt_level;
               `CMC_MS_OTHER: src = filtered[1-gi];
               `CMC_MS_TRIGGER: src = trig_sync;
               default: src = 1'b0;
            endcase
         end
         always @(posedge mclk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
            begin
               div_cnt <= 5'd0;
               same_cnt <= 3'd0;
               flt_level <= 1'b0;
               flt_prev <= 1'b0;
               edge_cnt <= 3'd0;
            end
            else
            begin
               if (code < 4'h4)
               begin
                  div_cnt <= 5'd0;
               end
               else if (dead_time_tick_i)
               begin
                  div_cnt <= (div_cnt >= div) ? 5'd0 : div_cnt + 5'd1;
               end
               if (code == 4'h0)
               begin
                  flt_level <= pin_sync[gi];
                  same_cnt <= 3'd0;
               end
               else if (samp)
               begin
                  if (pin_sync[gi] == flt_level)
                  begin
                     same_cnt <= 3'd0;
                  end
                  else if (same_cnt >= need)
                  begin
                     flt_level <= pin_sync[gi];
                     same_cnt <= 3'd0;
                  end
                  else
                  begin
                     same_cnt <= same_cnt + 3'd1;
                  end
               end
               flt_prev <= src;
               if (!ch_en[gi] || ms == `CMC_MS_OUTPUT)
               begin
                  edge_cnt <= 3'd0;
               end
               else if (src_edge)
               begin
                  edge_cnt <= (edge_cnt == psc_mask) ? 3'd0 :
                     edge_cnt + 3'd1;
               end
            end
         end
         assign src_edge = src && !flt_prev;
         assign rise[gi] = ch_en[gi] && ms != `CMC_MS_OUTPUT &&
            src_edge && edge_cnt == psc_mask;
         assign filtered[gi] = flt_level;
      end
   endgenerate

   // ****************************************************************
   // channel 0 prepared output
   // ****************************************************************
   reg next_prep;
   reg pwm_level;
   wire below;
   wire above;
   wire match;
   wire count_down;
   assign below = counter_i < ch0_compare_value_o;
   assign above = counter_i > ch0_compare_value_o;
   assign match = counter_i == ch0_compare_value_o;
   assign count_down = ctrl[`CMC_CTRL_COUNT_DOWN];
   always @*
   begin
      pwm_level = count_down ? !above : below;
      if (ch0_octl == `CMC_OC_PWM1)
      begin
         pwm_level = !pwm_level;
      end
      if (mode_ctl[`CMC_CH0_FAST_BIT] && trig_rise)
      begin
         pwm_level = ch0_octl == `CMC_OC_PWM0;
      end
      next_prep = ch0_prepared_output_o;
      case (ch0_octl)
         `CMC_OC_SET: next_prep = match ? 1'b1 : next_prep;
         `CMC_OC_CLEAR: next_prep = match ? 1'b0 : next_prep;
         `CMC_OC_TOGGLE: next_prep = match ^ next_prep;
         `CMC_OC_LOW: next_prep = 1'b0;
         `CMC_OC_HIGH: next_prep = 1'b1;
         `CMC_OC_PWM0: next_prep = pwm_level;
         `CMC_OC_PWM1: next_prep = pwm_level;
         default: next_prep = ch0_prepared_output_o;
      endcase
      if (mode_ctl[`CMC_CH0_CLEAR_BIT] && external_trigger_filtered_i)
      begin
         next_prep = 1'b0;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ch0_prepared_output_o <= 1'b0;
         capture_o <= 2'h0;
         rdata_o <= 32'h00000000;
      end
      else
      begin
         ch0_prepared_output_o <= (ch0_ms == `CMC_MS_OUTPUT) ?
            next_prep : 1'b0;
         capture_o <= rise;
         rdata_o <= 32'h00000000;
         if (rd_i)
         begin
            case (addr_i)
               `CMC_OFS_MODE_CTL: rdata_o <= {16'h0000, mode_ctl};
               `CMC_OFS_CMP_VALUE: rdata_o <= {16'h0000, cmp_shadow};
               `CMC_OFS_CTRL: rdata_o <= {27'h0000000, ctrl};
               `CMC_OFS_STATUS: rdata_o <= {28'h0000000, filtered,
                  trig_sync, ch0_prepared_output_o};
               default: rdata_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // chan01_mode_ctl
`default_nettype wire

// >>> shared/chan01_mode_map.vh
// register offsets, field positions, reset value and encodings
// for the channel 0/1 mode control block; included by the rtl file.
`ifndef CHAN01_MODE_MAP_VH
`define CHAN01_MODE_MAP_VH
// ****************************************************************
// register offsets (byte addresses, word access)
// ****************************************************************
`define CMC_ADDR_W 8
`define CMC_OFS_MODE_CTL 8'h18
`define CMC_OFS_CMP_VALUE 8'h34
`define CMC_OFS_CTRL 8'h40
`define CMC_OFS_STATUS 8'h44
`define CMC_MODE_CTL_RESET 16'h0000
// ****************************************************************
// mode control fields, output layout
// ****************************************************************
`define CMC_CH0_MS_LSB 0
`define CMC_CH0_FAST_BIT 2
`define CMC_CH0_SHADOW_BIT 3
`define CMC_CH0_OCTL_LSB 4
`define CMC_CH0_CLEAR_BIT 7
`define CMC_CH1_MS_LSB 8
// ****************************************************************
// mode control fields, input layout
// ****************************************************************
`define CMC_CH0_PSC_LSB 2
`define CMC_CH0_FLT_LSB 4
`define CMC_CH1_PSC_LSB 10
`define CMC_CH1_FLT_LSB 12
// ****************************************************************
// own control register fields
// ****************************************************************
`define CMC_CTRL_CH0_EN 0
`define CMC_CTRL_CH1_EN 1
`define CMC_CTRL_PROTECTION_LEVEL_LSB 2
`define CMC_CTRL_COUNT_DOWN 4
// ****************************************************************
// encodings
// ****************************************************************
`define CMC_MS_OUTPUT 2'b00
`define CMC_MS_OWN 2'b01
`define CMC_MS_OTHER 2'b10
`define CMC_MS_TRIGGER 2'b11
`define CMC_PROTECTION_LEVEL_LOCKED 2'b11
`define CMC_OC_TIMING 3'b000
`define CMC_OC_SET 3'b001
`define CMC_OC_CLEAR 3'b010
`define CMC_OC_TOGGLE 3'b011
`define CMC_OC_LOW 3'b100
`define CMC_OC_HIGH 3'b101
`define CMC_OC_PWM0 3'b110
`define CMC_OC_PWM1 3'b111
`define CMC_CMP_W 16
`endif

// >>> verification/chan01_mode_props.sv
// assertion checker for the channel 0/1 mode control block
// assumes it is bound to chan01_mode_ctl and sees only its ports
`default_nettype none
module chan01_mode_props
(
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic external_trigger_filtered_i,
   input wire logic update_event_i,
   input wire logic [15:0] counter_i,
   input wire logic [1:0] capture_o,
   input wire logic ch0_prepared_output_o,
   input wire logic [15:0] ch0_compare_value_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mc;
   logic [4:0] ctl;
   logic [15:0] cbuf;
   logic lock;
   logic below;
   logic [15:0] next_mc;
   // ****
   // register model
   // ****
   assign lock = ctl[3:2] == 2'b11 && mc[1:0] == 2'b00;
   assign next_mc = {wdata_i[15:10], ctl[1] ? mc[9:8] : wdata_i[9:8],
      wdata_i[7], lock ? mc[6:3] : wdata_i[6:3], wdata_i[2],
      ctl[0] ? mc[1:0] : wdata_i[1:0]};
   assign below = mc[1:0] == 2'b00 && !mc[7] && !ctl[4]
      && counter_i < ch0_compare_value_o;
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         mc <= 16'h0000;
         ctl <= 5'h00;
         cbuf <= 16'h0000;
      end
      else
      begin
         if (wr_i && addr_i == 8'h18)
            mc <= next_mc;
         if (wr_i && addr_i == 8'h40)
            ctl <= wdata_i[4:0];
         if (wr_i && addr_i == 8'h34)
            cbuf <= wdata_i[15:0];
      end
   end
   // ****
   // checks
   // ****
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   AST_READBACK: assert property (
      $past(rd_i && addr_i == 8'h18) |-> rdata_o == {16'h0, $past(mc)})
      else $error("mode control read back differs");
   AST_SHADOW_HOLD: assert property (
      mc[3] && !update_event_i |=> $stable(ch0_compare_value_o))
      else $error("compare changed without update");
   AST_SHADOW_LOAD: assert property (
      mc[3] && update_event_i |=> ch0_compare_value_o == $past(cbuf))
      else $error("update did not load compare");
   AST_DIRECT: assert property (
      !mc[3] && wr_i && addr_i == 8'h34
      |=> ch0_compare_value_o == $past(wdata_i[15:0]))
      else $error("direct compare write lost");
   AST_PREP_INPUT: assert property (
      $past(mc[1:0]) != 2'b00 |-> !ch0_prepared_output_o)
      else $error("prepared output high in input mode");
   AST_PWM0: assert property (
      (below && mc[6:4] == 3'b110) [*2] |=> ch0_prepared_output_o)
      else $error("pwm 0 output low below compare");
   AST_PWM1: assert property (
      (below && mc[6:4] == 3'b111) [*2] |=> !ch0_prepared_output_o)
      else $error("pwm 1 output high below compare");
   AST_CLEAR: assert property (
      (mc[7] && mc[1:0] == 2'b00 && external_trigger_filtered_i) [*2]
      |=> !ch0_prepared_output_o) else $error("clear did not hold low");
   AST_NO_CAPTURE: assert property (
      (!ctl[0]) [*6] |-> !capture_o[0])
      else $error("capture while channel disabled");
endmodule // chan01_mode_props
bind chan01_mode_ctl chan01_mode_props u_chan01_mode_props (.mclk_i(mclk_i),
   .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .update_event_i(update_event_i),
   .external_trigger_filtered_i(external_trigger_filtered_i),
   .counter_i(counter_i), .capture_o(capture_o),
   .ch0_prepared_output_o(ch0_prepared_output_o),
   .ch0_compare_value_o(ch0_compare_value_o));
`default_nettype wire

// >>> verification/chan_pin_model.sv
// stand-in for the two channel pins and the internal trigger source
// assumes bursts are requested by the bench one at a time
`default_nettype none
module chan_pin_model
(
   input wire logic clk_i,
   output logic [2:0] line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line_o = 3'b000;
   // line 0 and 1 are the pins, line 2 the trigger; low 12 cycles between
   task automatic burst(input int sel, input int num, input int width);
      repeat (num)
      begin
         line_o[sel] <= 1'b1;
         repeat (width) @(posedge clk_i);
         line_o[sel] <= 1'b0;
         repeat (12) @(posedge clk_i);
      end
   endtask
endmodule // chan_pin_model
`default_nettype wire

// >>> verification/chan01_mode_ctl_tb_top.sv
// self-checking bench for the channel 0/1 mode control block
// assumes the pin model and the bound checker beside the design
`default_nettype none
module chan01_mode_ctl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic ext = 1'b0;
   logic tick = 1'b0;
   logic upd = 1'b0;
   logic [15:0] counter = 16'h0000;
   logic [31:0] rdata;
   logic [1:0] capture;
   logic prep;
   logic [15:0] cmp;
   logic [2:0] line;
   int error_cnt = 0;
   int compares = 0;
   int caps = 0;
   int prep_hi = 0;
   int caps1 = 0;
   always #50 mclk = ~mclk;
   always @(posedge mclk)
   begin
      caps += int'(capture[0] === 1'b1);
      caps1 += int'(capture[1] === 1'b1);
      prep_hi += int'(prep === 1'b1);
   end
   chan01_mode_ctl u_chan01_mode_ctl (.mclk_i(mclk), .arst_n_i(arst_n),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
      .rdata_o(rdata), .ch_pin_i(line[1:0]), .internal_trigger_i(line[2]),
      .external_trigger_filtered_i(ext), .dead_time_tick_i(tick),
      .update_event_i(upd), .counter_i(counter), .capture_o(capture),
      .ch0_prepared_output_o(prep), .ch0_compare_value_o(cmp));
   chan_pin_model u_chan_pin_model (.clk_i(mclk), .line_o(line));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic t_regs;
      rd(8'h18, 32'h0);
      wr(8'h7c, 32'hffff_ffff);
      rd(8'h7c, 32'h0);
      wr(8'h18, 32'hffff_5a7c);
      rd(8'h18, 32'h0000_5a7c);
      wr(8'h40, 32'h3);
      wr(8'h18, 32'h0000_a5a3);
      rd(8'h18, 32'h0000_a6a0);
      wr(8'h40, 32'h0);
      wr(8'h18, 32'h0);
      wr(8'h40, 32'hc);
      wr(8'h18, 32'h7c);
      rd(8'h18, 32'h4);
      wr(8'h18, 32'h1);
      wr(8'h18, 32'h79);
      rd(8'h18, 32'h79);
      wr(8'h40, 32'h0);
   endtask
   task automatic t_capture;
      for (int m = 1; m < 4; m++)
      begin
         for (int p = 0; p < 4; p++)
         begin
            wr(8'h40, 32'h0);
            wr(8'h18, 32'(p * 4 + m));
            wr(8'h40, 32'h1);
            caps = 0;
            u_chan_pin_model.burst(m - 1, 8, 6);
            chk(caps, 8 >> p);
         end
      end
   endtask
   task automatic t_ch1;
      wr(8'h40, 32'h0);
      wr(8'h18, 32'h0500);
      wr(8'h40, 32'h2);
      caps1 = 0;
      u_chan_pin_model.burst(1, 4, 6);
      chk(caps1, 2);
      wr(8'h40, 32'h0);
   endtask
   task automatic t_filter;
      wr(8'h40, 32'h0);
      wr(8'h18, 32'h31);
      wr(8'h40, 32'h1);
      caps = 0;
      u_chan_pin_model.burst(0, 4, 3);
      chk(caps, 0);
      // seven equal samples are one short of the eight this code needs
      u_chan_pin_model.burst(0, 4, 7);
      chk(caps, 0);
      u_chan_pin_model.burst(0, 4, 12);
      chk(caps, 4);
      // divided rate: one sample every second tick, six samples needed
      tick <= 1'b1;
      wr(8'h18, 32'h41);
      caps = 0;
      u_chan_pin_model.burst(0, 2, 8);
      chk(caps, 0);
      u_chan_pin_model.burst(0, 1, 20);
      settle(12);
      chk(caps, 1);
   endtask
   task automatic t_psc_reset;
      wr(8'h40, 32'h0);
      wr(8'h18, 32'hd);
      wr(8'h40, 32'h1);
      caps = 0;
      u_chan_pin_model.burst(0, 4, 6);
      wr(8'h40, 32'h0);
      wr(8'h40, 32'h1);
      u_chan_pin_model.burst(0, 4, 6);
      chk(caps, 0);
      u_chan_pin_model.burst(0, 4, 6);
      chk(caps, 1);
   endtask
   task automatic t_compare;
      wr(8'h40, 32'h0);
      wr(8'h18, 32'h68);
      wr(8'h34, 32'h100);
      settle(3);
      chk(cmp, 16'h0);
      upd <= 1'b1;
      counter <= 16'h0010;
      settle(1);
      upd <= 1'b0;
      settle(3);
      chk(cmp, 16'h100);
      chk(prep, 1'b1);
      wr(8'h18, 32'h78);
      settle(3);
      chk(prep, 1'b0);
      counter <= 16'h0200;
      wr(8'h18, 32'h6c);
      settle(3);
      chk(prep, 1'b0);
      prep_hi = 0;
      u_chan_pin_model.burst(2, 1, 6);
      chk(prep_hi > 0, 1'b1);
      counter <= 16'h0010;
      wr(8'h18, 32'he8);
      ext <= 1'b1;
      settle(3);
      chk(prep, 1'b0);
      ext <= 1'b0;
      wr(8'h18, 32'h60);
      wr(8'h34, 32'h55);
      chk(cmp, 16'h55);
      rd(8'h34, 32'h55);
      rd(8'h40, 32'h0);
      rd(8'h44, 32'h1);
   endtask
   task automatic tally_and_finish;
      $display("Checks: %0d, mismatches: %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      settle(16);
      arst_n <= 1'b1;
      settle(1);
      t_regs;
      t_capture;
      t_ch1;
      t_filter;
      t_psc_reset;
      t_compare;
      tally_and_finish;
   end
endmodule // chan01_mode_ctl_tb_top
`default_nettype wire
